// ---- core/gswc_pkg.sv ----
// Package of constants, carriers and mode type for the green/sleep wakeup controller.
// Functional notes
// (R1) Setting the green-mode request bit halts execution and enters green mode.
// (R2) Any wakeup from green mode clears the green-mode request bit in hardware.
// (R3) The wakeup timer keeps counting in green mode when enabled, on the system clock.
// (R4) In green mode everything except the wakeup timer is inactive.
// (R5) In green mode the oscillator feeding the system clock runs; others keep their configured state.
// (R6) Green mode wakes only on a wake-enabled port 0/1 pin change or a wakeup timer overflow.
// (R7) A green-mode wakeup returns to the mode it was entered from, normal or slow.
// (R8) Power-down wakes only on a port 0/1 pin change, never on timer overflow, and then enters normal mode.
// (R9) After a power-down wakeup, 2048 high-speed oscillator cycles elapse before normal execution resumes.
// (R10) A green-mode wakeup resumes execution at once with no stabilisation delay.
// (R11) Every port 0 pin always has level-change wakeup enabled, with no mask.
// (R12) Bit n of the port 1 wake-enable register gates wakeup from port 1 pin n; all bits reset to 0.
// (R13) Setting the sleep request bit stops all oscillators and enters power-down; hardware clears it on wakeup.
// (R14) The slow-clock select bit picks normal (0) or slow mode (1), slow running the CPU at low RC / 4.
// (R15) A level change is an enabled synchronised pin differing from its value captured at mode entry.
package gswc_pkg;

    localparam int GSWC_ADDR_W = 8;
    localparam int GSWC_DATA_W = 32;
    localparam int GSWC_PORT_W = 8;
    localparam int GSWC_TMR_W = 8;
    localparam int GSWC_INT_W = 3;
    localparam int GSWC_WARM_CNT_W = 12;
    localparam int GSWC_DIV_W = 2;

    // Register byte addresses
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_P1_WAKE = 8'hC0;
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_OSC_MODE = 8'hC4;
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_TIMER = 8'hC8;
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_MODE_STAT = 8'hCC;
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_INT_STAT = 8'hD0;
    localparam logic [GSWC_ADDR_W-1:0] GSWC_OFS_INT_MASK = 8'hD4;

    // Oscillator mode register fields
    localparam int GSWC_OSC_SLEEP_BIT = 0;
    localparam int GSWC_OSC_GREEN_BIT = 1;
    localparam int GSWC_OSC_SLOW_BIT = 2;
    localparam int GSWC_OSC_HSTOP_BIT = 3;

    // Timer register fields
    localparam int GSWC_TMR_EN_BIT = 0;
    localparam int GSWC_TMR_RELOAD_LSB = 8;
    localparam int GSWC_TMR_COUNT_LSB = 16;

    // Interrupt status and mask fields
    localparam int GSWC_INT_GREEN_WAKE = 0;
    localparam int GSWC_INT_SLEEP_WAKE = 1;
    localparam int GSWC_INT_TMR_OVF = 2;

    // Reset values
    localparam logic [GSWC_PORT_W-1:0] GSWC_P1_WAKE_RST = 8'h00;
    localparam logic [GSWC_TMR_W-1:0] GSWC_TMR_RELOAD_RST = 8'h00;
    localparam logic [GSWC_INT_W-1:0] GSWC_INT_MASK_RST = 3'h0;

    // Timing
    localparam int GSWC_WARMUP_CYCLES = 2048;
    localparam int GSWC_SLOW_DIV = 4;

    typedef enum logic [2:0] {
        GSWC_NORMAL,
        GSWC_SLOW,
        GSWC_GREEN,
        GSWC_SLEEP,
        GSWC_WARMUP
    } gswc_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [GSWC_ADDR_W-1:0] paddr;
        logic [GSWC_DATA_W-1:0] pwdata;
    } gswc_apb_req_t;

    typedef struct packed {
        logic [GSWC_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } gswc_apb_rsp_t;

    typedef struct packed {
        logic high_osc_en;
        logic low_osc_en;
    } gswc_osc_ctl_t;

endpackage : gswc_pkg

// ---- core/gswc_sync.sv ----
// Two-flop synchroniser for a bus of independent level inputs.
`timescale 1ns/1ns
`default_nettype none
module gswc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gswc_sync_state_t;

    gswc_sync_state_t s_q;
    gswc_sync_state_t s_d;

    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;

endmodule : gswc_sync
`default_nettype wire

// ---- core/gswc_wake_timer.sv ----
// Reloading up-counter whose overflow can wake the system from green mode.
`timescale 1ns/1ns
`default_nettype none
module gswc_wake_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic [W-1:0] reload,
    // Status
    output logic [W-1:0] count,
    output logic ovf
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic ovf;
    } gswc_tmr_state_t;

    gswc_tmr_state_t s_q;
    gswc_tmr_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.ovf = 1'b0;
        if (run) begin
            if (&s_q.cnt) begin
                s_d.cnt = reload;
                s_d.ovf = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
    assign ovf = s_q.ovf;

endmodule : gswc_wake_timer
`default_nettype wire

// ---- core/gswc_top.sv ----
// Operating-mode and wakeup controller with APB registers and interrupt.
`timescale 1ns/1ns
`default_nettype none
module gswc_top
    import gswc_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = GSWC_WARMUP_CYCLES,
    parameter int PORT_W = GSWC_PORT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // APB slave
    input wire gswc_apb_req_t apb_req,
    output gswc_apb_rsp_t apb_rsp,
    // Wake pins and low-speed oscillator level
    input wire logic [PORT_W-1:0] port0_pins,
    input wire logic [PORT_W-1:0] port1_pins,
    input wire logic low_osc_level,
    // CPU and peripheral control
    output logic cpu_run,
    output logic periph_en,
    output logic cpu_slow_sel,
    output logic cpu_slow_tick,
    // Oscillator control
    output gswc_osc_ctl_t osc_ctl,
    // Interrupt
    output logic irq
);

    // Port 0, port 1 and the low RC level share one synchroniser
    localparam int SYNC_W = 2 * PORT_W + 1;
    // Warm-up counter ends one short of the cycle count
    localparam logic [GSWC_WARM_CNT_W-1:0] WARM_LAST = GSWC_WARM_CNT_W'(WARMUP_CYCLES - 1);
    localparam logic [GSWC_DIV_W-1:0] DIV_LAST = GSWC_DIV_W'(GSWC_SLOW_DIV - 1);

    typedef struct packed {
        // Mode sequencing
        gswc_mode_t mode;
        logic prev_slow;

        // Register fields
        logic [PORT_W-1:0] p1_wake_en;
        logic green_req;
        logic sleep_req;
        logic slow_sel;
        logic high_stop;
        logic tmr_en;
        logic [GSWC_TMR_W-1:0] tmr_reload;

        // Wake detection, warm-up and interrupts
        logic [PORT_W-1:0] p0_snap;
        logic [PORT_W-1:0] p1_snap;
        logic [GSWC_WARM_CNT_W-1:0] warm_cnt;
        logic [GSWC_INT_W-1:0] int_stat;
        logic [GSWC_INT_W-1:0] int_mask;

        // Slow-clock divider
        logic lrc_prev;
        logic [GSWC_DIV_W-1:0] slow_div;

        // Registered outputs
        gswc_apb_rsp_t apb;
        gswc_osc_ctl_t osc;
        logic irq;
        logic cpu_run;
        logic periph_en;
        logic slow_out;
        logic slow_tick;
    } gswc_top_state_t;

    gswc_top_state_t s_q;
    gswc_top_state_t s_d;

    // Synchronised pins and timer status
    logic [SYNC_W-1:0] sync_q;
    logic [PORT_W-1:0] p0_s;
    logic [PORT_W-1:0] p1_s;
    logic lrc_s;
    logic [GSWC_TMR_W-1:0] tmr_count;
    logic tmr_ovf;
    logic tmr_run;

    // Pins and the low RC level come from outside the clock domain
    gswc_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d({low_osc_level, port1_pins, port0_pins}),
        .q(sync_q)
    );

    assign p0_s = sync_q[PORT_W-1:0];
    assign p1_s = sync_q[2*PORT_W-1:PORT_W];
    assign lrc_s = sync_q[SYNC_W-1];

    // Timer is stopped only in power-down and its warm-up
    assign tmr_run = s_q.tmr_en && (s_q.mode == GSWC_NORMAL || s_q.mode == GSWC_SLOW
                                    || s_q.mode == GSWC_GREEN); // R3

    gswc_wake_timer #(
        .W(GSWC_TMR_W)
    ) u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .run(tmr_run),
        .reload(s_q.tmr_reload),
        .count(tmr_count),
        .ovf(tmr_ovf)
    );

    always_comb begin
        logic acc;
        logic done;
        logic hit;
        logic wr;
        logic pin_change;
        logic [GSWC_DATA_W-1:0] rd_val;
        logic [GSWC_INT_W-1:0] events;
        logic [GSWC_INT_W-1:0] w1c;

        acc = 1'b0;
        done = 1'b0;
        hit = 1'b0;
        wr = 1'b0;
        pin_change = 1'b0;
        rd_val = '0;
        events = '0;
        w1c = '0;

        // Hold every field unless a branch below changes it
        s_d = s_q;
        s_d.slow_tick = 1'b0;

        // Level-change detect against the values captured at mode entry
        pin_change = |(p0_s ^ s_q.p0_snap)                      // R11 R15
                   | |((p1_s ^ s_q.p1_snap) & s_q.p1_wake_en); // R12 R15

        // Address decode and read mux
        unique case (apb_req.paddr)
            GSWC_OFS_P1_WAKE: begin
                hit = 1'b1;
            end
            GSWC_OFS_OSC_MODE: begin
                hit = 1'b1;
                rd_val[GSWC_OSC_SLEEP_BIT] = s_q.sleep_req;
                rd_val[GSWC_OSC_GREEN_BIT] = s_q.green_req;
                rd_val[GSWC_OSC_SLOW_BIT] = s_q.slow_sel;
                rd_val[GSWC_OSC_HSTOP_BIT] = s_q.high_stop;
            end
            GSWC_OFS_TIMER: begin
                hit = 1'b1;
                rd_val[GSWC_TMR_EN_BIT] = s_q.tmr_en;
                rd_val[GSWC_TMR_RELOAD_LSB +: GSWC_TMR_W] = s_q.tmr_reload;
                rd_val[GSWC_TMR_COUNT_LSB +: GSWC_TMR_W] = tmr_count;
            end
            GSWC_OFS_MODE_STAT: begin
                hit = 1'b1;
                rd_val = GSWC_DATA_W'(s_q.mode);
            end
            GSWC_OFS_INT_STAT: begin
                hit = 1'b1;
                rd_val = GSWC_DATA_W'(s_q.int_stat);
            end
            GSWC_OFS_INT_MASK: begin
                hit = 1'b1;
                rd_val = GSWC_DATA_W'(s_q.int_mask);
            end
            // Unmapped offsets answer with an error
            default: begin
                hit = 1'b0;
            end
        endcase

        // One wait state so that the answer leaves a flip-flop
        acc = apb_req.psel && apb_req.penable;
        done = acc && s_q.apb.pready;
        s_d.apb.pready = acc && !s_q.apb.pready;
        if (acc && !s_q.apb.pready) begin
            s_d.apb.prdata = apb_req.pwrite ? '0 : rd_val;
            s_d.apb.pslverr = !hit;
        end else begin
            s_d.apb.prdata = '0;
            s_d.apb.pslverr = 1'b0;
        end

        // Register writes take effect at the completing edge
        wr = done && apb_req.pwrite && hit;
        if (wr) begin
            unique case (apb_req.paddr)
                GSWC_OFS_P1_WAKE: begin
                    s_d.p1_wake_en = apb_req.pwdata[PORT_W-1:0]; // R12
                end
                GSWC_OFS_OSC_MODE: begin
                    // A low-power request is acted on at the next edge
                    s_d.sleep_req = apb_req.pwdata[GSWC_OSC_SLEEP_BIT]; // R13
                    s_d.green_req = apb_req.pwdata[GSWC_OSC_GREEN_BIT]; // R1
                    s_d.slow_sel = apb_req.pwdata[GSWC_OSC_SLOW_BIT]; // R14
                    s_d.high_stop = apb_req.pwdata[GSWC_OSC_HSTOP_BIT];
                end
                GSWC_OFS_TIMER: begin
                    s_d.tmr_en = apb_req.pwdata[GSWC_TMR_EN_BIT];
                    s_d.tmr_reload = apb_req.pwdata[GSWC_TMR_RELOAD_LSB +: GSWC_TMR_W];
                end
                GSWC_OFS_INT_STAT: begin
                    w1c = apb_req.pwdata[GSWC_INT_W-1:0];
                end
                GSWC_OFS_INT_MASK: begin
                    s_d.int_mask = apb_req.pwdata[GSWC_INT_W-1:0];
                end
                default: begin
                    s_d.int_mask = s_q.int_mask;
                end
            endcase
        end

        // Overflow is flagged in every mode, so software can poll it
        events[GSWC_INT_TMR_OVF] = tmr_ovf;

        // Mode sequencing reacts to the registered request bits
        unique case (s_q.mode)
            GSWC_NORMAL, GSWC_SLOW: begin
                // Snapshot follows the pins until a low-power mode freezes it
                s_d.p0_snap = p0_s;
                s_d.p1_snap = p1_s;
                if (s_q.sleep_req) begin
                    s_d.mode = GSWC_SLEEP; // R13
                end else if (s_q.green_req) begin
                    s_d.mode = GSWC_GREEN; // R1
                    s_d.prev_slow = (s_q.mode == GSWC_SLOW); // R7
                end else begin
                    s_d.mode = s_q.slow_sel ? GSWC_SLOW : GSWC_NORMAL; // R14
                end
            end
            GSWC_GREEN: begin
                // No warm-up: the system clock kept running
                if (pin_change || tmr_ovf) begin // R6
                    s_d.mode = s_q.prev_slow ? GSWC_SLOW : GSWC_NORMAL; // R7 R10
                    s_d.green_req = 1'b0; // R2
                    events[GSWC_INT_GREEN_WAKE] = 1'b1;
                end
            end
            GSWC_SLEEP: begin
                // The timer does not count here; only pins wake
                if (pin_change) begin // R8
                    s_d.mode = GSWC_WARMUP;
                    s_d.warm_cnt = '0;
                    s_d.sleep_req = 1'b0; // R13
                    s_d.slow_sel = 1'b0; // R8
                end
            end
            GSWC_WARMUP: begin
                // Pin changes are ignored while the oscillator settles
                if (s_q.warm_cnt == WARM_LAST) begin // R9
                    s_d.mode = GSWC_NORMAL; // R8
                    events[GSWC_INT_SLEEP_WAKE] = 1'b1;
                end else begin
                    s_d.warm_cnt = s_q.warm_cnt + 1'b1; // R9
                end
            end
            default: begin
                s_d.mode = GSWC_NORMAL;
            end
        endcase

        // Hardware set wins over a same-cycle clear
        s_d.int_stat = (s_q.int_stat & ~w1c) | events;

        // Slow-mode CPU tick: low RC rising edges divided down
        // Divider free-runs; only slow mode lets the tick out
        s_d.lrc_prev = lrc_s;
        if (lrc_s && !s_q.lrc_prev) begin
            if (s_q.slow_div == DIV_LAST) begin
                s_d.slow_div = '0;
                // Next mode, so the tick never leads or trails the slow select
                s_d.slow_tick = (s_d.mode == GSWC_SLOW); // R14
            end else begin
                s_d.slow_div = s_q.slow_div + 1'b1;
            end
        end

        // Outputs follow the next mode so they change with it
        s_d.cpu_run = (s_d.mode == GSWC_NORMAL) || (s_d.mode == GSWC_SLOW); // R1 R9 R10
        s_d.periph_en = s_d.cpu_run; // R4
        s_d.slow_out = (s_d.mode == GSWC_SLOW);
        // Oscillator enables follow the next mode
        unique case (s_d.mode)
            GSWC_NORMAL, GSWC_WARMUP: begin
                s_d.osc.high_osc_en = 1'b1;
                s_d.osc.low_osc_en = 1'b1;
            end
            GSWC_SLOW: begin
                s_d.osc.high_osc_en = !s_d.high_stop;
                s_d.osc.low_osc_en = 1'b1;
            end
            GSWC_GREEN: begin
                // The clock source stays; the other one keeps its prior setting
                s_d.osc.high_osc_en = s_d.prev_slow ? !s_d.high_stop : 1'b1; // R5
                s_d.osc.low_osc_en = 1'b1; // R5
            end
            GSWC_SLEEP: begin
                s_d.osc.high_osc_en = 1'b0; // R13
                s_d.osc.low_osc_en = 1'b0; // R13
            end
            default: begin
                s_d.osc.high_osc_en = 1'b1;
                s_d.osc.low_osc_en = 1'b1;
            end
        endcase
        // Level interrupt from masked sticky status
        s_d.irq = |(s_d.int_stat & s_d.int_mask);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;

            // Leave reset in normal mode with both oscillators on
            s_q.mode <= GSWC_NORMAL;
            s_q.p1_wake_en <= GSWC_P1_WAKE_RST; // R12
            s_q.tmr_reload <= GSWC_TMR_RELOAD_RST;
            s_q.int_mask <= GSWC_INT_MASK_RST;
            s_q.cpu_run <= 1'b1;
            s_q.periph_en <= 1'b1;
            s_q.osc.high_osc_en <= 1'b1;
            s_q.osc.low_osc_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output leaves a flip-flop of the state
    assign apb_rsp = s_q.apb;
    assign osc_ctl = s_q.osc;
    assign irq = s_q.irq;
    assign cpu_run = s_q.cpu_run;
    assign periph_en = s_q.periph_en;
    assign cpu_slow_sel = s_q.slow_out;
    assign cpu_slow_tick = s_q.slow_tick;

endmodule : gswc_top
`default_nettype wire

// ---- testbench/gswc_checker.sv ----
// Concurrent checks on the wakeup controller ports.
`timescale 1ns/1ns
`default_nettype none
module gswc_checker
    import gswc_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = GSWC_WARMUP_CYCLES,
    parameter int PORT_W = GSWC_PORT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Bus
    input wire gswc_apb_req_t apb_req,
    input wire gswc_apb_rsp_t apb_rsp,
    // Pins
    input wire logic [PORT_W-1:0] port0_pins,
    input wire logic [PORT_W-1:0] port1_pins,
    input wire logic low_osc_level,
    // Control
    input wire logic cpu_run,
    input wire logic periph_en,
    input wire logic cpu_slow_sel,
    input wire logic cpu_slow_tick,
    input wire gswc_osc_ctl_t osc_ctl,
    input wire logic irq
);
    logic sleep_s;
    logic green_s;
    logic warm_q;
    logic [15:0] warm_cnt_q;
    logic [3:0] quiet_q;
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!arst_n);
    assign sleep_s = !cpu_run && !osc_ctl.high_osc_en && !osc_ctl.low_osc_en;
    // Warmup shows the same outputs as green, so it is told apart by history
    assign green_s = !cpu_run && osc_ctl.low_osc_en && !warm_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            warm_q <= 1'b0;
            warm_cnt_q <= 16'h0000;
            quiet_q <= 4'hF;
        end else begin
            if ($fell(sleep_s)) begin
                warm_q <= 1'b1;
                warm_cnt_q <= 16'h0000;
            end else if (warm_q && cpu_run) begin
                warm_q <= 1'b0;
            end else if (warm_q) begin
                warm_cnt_q <= warm_cnt_q + 16'h0001;
            end
            if ($changed(port0_pins) || $changed(port1_pins)) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hF) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end
    sequence osc_wr_s;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == GSWC_OFS_OSC_MODE;
    endsequence
    AST_LP_ENTRY: assert property (
        osc_wr_s ##0 (apb_req.pwdata[1:0] != 2'h0) |-> ##[1:3] !cpu_run)
        else $error("Low-power request did not halt the CPU");
    AST_SLEEP_OSC: assert property (
        osc_wr_s ##0 apb_req.pwdata[0] |-> ##[1:3] (osc_ctl == 2'b00))
        else $error("Oscillators still on in power-down");
    AST_PERIPH_OFF: assert property (
        periph_en == cpu_run)
        else $error("Peripherals active while CPU halted");
    AST_GREEN_WAKE: assert property (
        green_s && $changed(port0_pins) |-> ##[1:4] cpu_run)
        else $error("Green wake too slow");
    AST_SLEEP_WAKE: assert property (
        sleep_s && $changed(port0_pins) |-> ##[1:4] !sleep_s)
        else $error("Port 0 change did not end power-down");
    AST_SLEEP_QUIET: assert property (
        $fell(sleep_s) |-> quiet_q < 4'h6)
        else $error("Power-down left without a pin change");
    AST_WARMUP_LEN: assert property (
        warm_q && cpu_run |-> warm_cnt_q + 2 >= WARMUP_CYCLES && warm_cnt_q <= WARMUP_CYCLES + 1)
        else $error("Warmup length wrong");
    AST_SLOW_OSC: assert property (
        cpu_slow_sel |-> osc_ctl.low_osc_en)
        else $error("Slow mode without low oscillator");
    AST_SLOW_TICK: assert property (
        cpu_slow_tick |-> cpu_slow_sel ##1 !cpu_slow_tick [*7])
        else $error("Slow tick spacing wrong");
endmodule : gswc_checker
bind gswc_top gswc_checker #(.WARMUP_CYCLES(WARMUP_CYCLES), .PORT_W(PORT_W)) u_chk (.clock(clock),
    .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .port0_pins(port0_pins), .port1_pins(port1_pins),
    .low_osc_level(low_osc_level), .cpu_run(cpu_run), .periph_en(periph_en), .cpu_slow_sel(cpu_slow_sel),
    .cpu_slow_tick(cpu_slow_tick), .osc_ctl(osc_ctl), .irq(irq));
`default_nettype wire

// ---- testbench/gswc_pin_model.sv ----
// Model of the port pins and the low-speed RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module gswc_pin_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Commands
    input wire logic [7:0] p0_want,
    input wire logic [7:0] p1_want,
    input wire logic low_osc_en,
    // Pins
    output logic [7:0] port0_pins,
    output logic [7:0] port1_pins,
    output logic low_osc_level
);
    logic [1:0] ph_q;
    assign port0_pins = p0_want;
    assign port1_pins = p1_want;
    // The RC oscillator stands still while stopped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ph_q <= 2'h0;
            low_osc_level <= 1'b0;
        end else if (low_osc_en) begin
            ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            low_osc_level <= (ph_q == 2'h2) ? !low_osc_level : low_osc_level;
        end
    end
endmodule : gswc_pin_model
`default_nettype wire

// ---- testbench/tb_green_sleep_wakeup_control.sv ----
// Self-checking testbench with a mode model.
`timescale 1ns/1ns
`default_nettype none
module tb_green_sleep_wakeup_control
    import gswc_pkg::*;
;
    localparam int WARM = 8;
    logic clock;
    logic arst_n;
    gswc_apb_req_t req;
    gswc_apb_rsp_t rsp;
    logic [7:0] p0_want;
    logic [7:0] p1_want;
    logic [7:0] p0;
    logic [7:0] p1;
    logic lo;
    logic run;
    logic tick;
    logic irq;
    gswc_osc_ctl_t osc;
    int n_mismatch = 0;
    int total_checks = 0;
    int exp_mode;
    int prior_q[$];
    gswc_top #(.WARMUP_CYCLES(WARM), .PORT_W(8)) uut (.clock(clock), .arst_n(arst_n), .apb_req(req),
        .apb_rsp(rsp), .port0_pins(p0), .port1_pins(p1), .low_osc_level(lo), .cpu_run(run), .periph_en(),
        .cpu_slow_sel(), .cpu_slow_tick(tick), .osc_ctl(osc), .irq(irq));
    gswc_pin_model u_pins (.clock(clock), .arst_n(arst_n), .p0_want(p0_want), .p1_want(p1_want),
        .low_osc_en(osc.low_osc_en), .port0_pins(p0), .port1_pins(p1), .low_osc_level(lo));
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge clock);
        req.penable <= 1'b1;
        @(posedge clock);
        while (rsp.pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clock);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, wd, rd, err);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, experr}, "slave error");
    endtask : rdchk
    task automatic wait_run(input logic v, input int lim, output int n);
        n = 0;
        while (run !== v && n < lim) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, run}, {31'h0, v}, "cpu run");
    endtask : wait_run
    task automatic enter(input logic [31:0] v, input int m);
        int n;
        if (m == 2)
            prior_q.push_back(exp_mode);
        exp_mode = m;
        wr(GSWC_OFS_OSC_MODE, v);
        wait_run(1'b0, 8, n);
        rdchk(GSWC_OFS_MODE_STAT, 32'(exp_mode), 1'b0);
    endtask : enter
    task automatic wake(input int lim, output int n);
        wait_run(1'b1, lim, n);
        exp_mode = (exp_mode == 2) ? prior_q.pop_back() : 0;
        rdchk(GSWC_OFS_MODE_STAT, 32'(exp_mode), 1'b0);
        rdchk(GSWC_OFS_OSC_MODE, (exp_mode == 1) ? 32'h4 : 32'h0, 1'b0);
    endtask : wake
    task automatic irqchk(input logic v);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, {31'h0, v}, "irq level");
    endtask : irqchk
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Whole run needs some 650 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
    initial begin
        logic [7:0] en;
        logic [31:0] d1;
        logic [31:0] d2;
        logic e;
        int n;
        arst_n = 1'b0;
        req = '0;
        p0_want = 8'h00;
        p1_want = 8'h00;
        exp_mode = 0;
        en = 8'($urandom(32'hA287));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rdchk(GSWC_OFS_OSC_MODE, 32'h0, 1'b0);
        rdchk(GSWC_OFS_MODE_STAT, 32'h0, 1'b0);
        rdchk(8'hE0, 32'h0, 1'b1);
        en = (en & 8'hFC) | 8'h01;
        wr(GSWC_OFS_P1_WAKE, {24'h0, en});
        rdchk(GSWC_OFS_P1_WAKE, 32'h0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            enter(32'h2, 2);
            p0_want <= p0_want ^ 8'($urandom() | (1 << i));
            wake(6, n);
        end
        enter(32'h2, 2);
        p1_want <= 8'h02;
        repeat (10) @(posedge clock);
        chk({31'h0, run}, 32'h0, "disabled pin woke");
        p1_want <= 8'h03;
        wake(6, n);
        wr(GSWC_OFS_OSC_MODE, 32'h4);
        exp_mode = 1;
        rdchk(GSWC_OFS_MODE_STAT, 32'h1, 1'b0);
        n = 0;
        while (tick !== 1'b1 && n < 80) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, tick}, 32'h1, "slow tick");
        wr(GSWC_OFS_TIMER, 32'h1);
        enter(32'h6, 2);
        apb(1'b0, GSWC_OFS_TIMER, 32'h0, d1, e);
        apb(1'b0, GSWC_OFS_TIMER, 32'h0, d2, e);
        chk({31'h0, d1[23:16] != d2[23:16]}, 32'h1, "timer stalled");
        wake(300, n);
        wr(GSWC_OFS_TIMER, 32'h0);
        wr(GSWC_OFS_INT_MASK, 32'h4);
        irqchk(1'b1);
        wr(GSWC_OFS_INT_STAT, 32'h4);
        irqchk(1'b0);
        wr(GSWC_OFS_INT_MASK, 32'h1);
        irqchk(1'b1);
        wr(GSWC_OFS_INT_STAT, 32'h7);
        irqchk(1'b0);
        wr(GSWC_OFS_TIMER, 32'h0000F001);
        enter(32'h5, 3);
        repeat (40) @(posedge clock);
        chk({30'h0, osc}, 32'h0, "oscillators on");
        rdchk(GSWC_OFS_MODE_STAT, 32'h3, 1'b0);
        p0_want <= ~p0_want;
        wake(WARM + 20, n);
        chk(n, WARM + 4, "warmup length");
        rdchk(GSWC_OFS_INT_STAT, 32'h2, 1'b0);
        stop_test();
    end
endmodule : tb_green_sleep_wakeup_control
`default_nettype wire
